// ===== logic/irq_tb_map.svh
// register offsets, field positions, reset values and timing counts of the interrupt block
`ifndef IRQ_TB_MAP_SVH
`define IRQ_TB_MAP_SVH
`define OFS_EDGE_SEL      4'h0
`define OFS_CTRL0         4'h1
`define OFS_CTRL1         4'h2
`define OFS_CTRL2         4'h3
`define OFS_PRESCALER     4'h4
`define OFS_TICK0         4'h5
`define OFS_TICK1         4'h6
`define OFS_CORE          4'h7
`define RST_BYTE          8'h00
`define BIT_RUN           7
`define PER_LSB_BITS      8
`define SRC_COUNT         8
`define DIV4_COUNT        2'h3
`define VEC_BASE          12'h004
`define VEC_STEP          12'h004
`endif

// ===== logic/irq_tb_pkg.sv
// types shared by the interrupt block
package irq_tb_pkg;
  typedef enum logic [1:0] {
    EDGE_OFF  = 2'h0,
    EDGE_RISE = 2'h1,
    EDGE_FALL = 2'h2,
    EDGE_BOTH = 2'h3
  } edge_mode_t;
  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_ENTER = 2'h1,
    ST_ACK   = 2'h3
  } seq_state_t;
endpackage : irq_tb_pkg

// ===== logic/tick_divider.sv
// one time-base divider with selectable overflow period
`timescale 1ns/10ps
`include "irq_tb_map.svh"
module tick_divider (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       tick_i,
  input  wire logic       run_i,
  input  wire logic [2:0] period_sel_i,
  output logic            overflow_o
);
  logic [15:0] count_q;
  logic [15:0] period_last;
  always_comb begin
    period_last = 16'h00FF;
    for (int i = 0; i < 8; i++) begin
      if (period_sel_i == 3'(i)) begin
        period_last = 16'((32'h1 << (`PER_LSB_BITS + i)) - 1);
      end
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i || !run_i) begin
      count_q    <= 16'h0000;
      overflow_o <= 1'b0;
    end else begin
      overflow_o <= 1'b0;
      if (tick_i) begin
        if (count_q >= period_last) begin
          count_q    <= 16'h0000;
          overflow_o <= 1'b1;
        end else begin
          count_q <= count_q + 16'h0001;
        end
      end
    end
  end
endmodule : tick_divider

// ===== logic/vectored_irq.sv
// vectored interrupt controller with two time-base generators and a wishbone slave
`timescale 1ns/10ps
`include "irq_tb_map.svh"
// Operation
// - event sets flag; branch only when that source's enable is high
// - global enable low blocks every vector branch
// - taking an interrupt pushes next pc and loads source vector
// - return from interrupt pops saved pc to resume
// - entering service clears global enable, blocking nesting
// - flags still latch while service is blocked
// - stack full holds off acknowledge until stack pointer decrements
// - simultaneous requests resolved by fixed priority
// - any flag rising wakes the device regardless of enables
// - external flag set on selected pin transition
// - servicing clears the serviced source's flag automatically
// - edge select offers rising, falling, both or disabled
// - edge encoding 00 off, 01 rising, 10 falling, 11 both
// - converter flag set when a conversion finishes
// - eeprom flag set at end of each write cycle
// - timer gives separate match p and match a requests
// - spi or i2c byte, address match or time-out sets serial flag
// - uart tx empty, idle, rx data, overrun, address, wake set serial flag
// - servicing a uart cause leaves uart status flags untouched
// - each time-base sets its flag on every divider overflow
// - prescaler source 00 system, 01 system/4, 1x slow clock
// - period code n gives 2^(8+n) prescaler cycles
module vectored_irq (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [3:0]  adr_i,
  input  wire logic [7:0]  dat_i,
  input  wire logic        we_i,
  input  wire logic [0:0]  sel_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  output logic [7:0]       dat_o,
  output logic             ack_o,
  input  wire logic        ext_pin_i,
  input  wire logic        slow_sub_clk_i,
  input  wire logic        conv_done_i,
  input  wire logic        eeprom_write_done_i,
  input  wire logic        match_p_i,
  input  wire logic        match_a_i,
  input  wire logic        serial_event_i,
  input  wire logic [11:0] next_pc_i,
  input  wire logic        irq_window_i,
  input  wire logic        return_from_irq_i,
  input  wire logic        stack_full_i,
  output logic             irq_take_o,
  output logic [11:0]      push_pc_o,
  output logic [11:0]      vector_o,
  output logic             pop_o,
  output logic             wake_o
);
  localparam int NSRC = `SRC_COUNT;
  // source index order is priority order, index 0 = lowest vector
  localparam int S_EXT = 0;
  localparam int S_SER = 1;
  localparam int S_ADC = 2;
  localparam int S_EEP = 3;
  localparam int S_MP  = 4;
  localparam int S_MA  = 5;
  localparam int S_TB0 = 6;
  localparam int S_TB1 = 7;

  logic [1:0]      ext_edge_select_q;
  logic            global_irq_enable_q;
  logic [NSRC-1:0] enable_q;
  logic [NSRC-1:0] flag_q;
  logic [1:0]      prescaler_src_sel_q;
  logic            tick0_run_q;
  logic [2:0]      tick0_period_sel_q;
  logic            tick1_run_q;
  logic [2:0]      tick1_period_sel_q;
  logic [2:0]      pin_sync_q;
  logic            pin_level_q;
  logic [2:0]      slow_sync_q;
  logic            slow_level_q;
  logic [1:0]      div4_q;
  logic            psc_tick;
  logic            tb0_ovf;
  logic            tb1_ovf;
  logic [NSRC-1:0] event_d;
  logic [NSRC-1:0] wr_mask;
  logic [NSRC-1:0] wr_value;
  logic [NSRC-1:0] svc_clear;
  logic [NSRC-1:0] pending;
  logic [2:0]      winner;
  logic            any_pending;
  logic            bus_req;
  logic            bus_wr;
  irq_tb_pkg::seq_state_t state_q;

  // three-stage capture: a change counts once stages two and three agree
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_sync_q  <= 3'h0;
      pin_level_q <= 1'b0;
      slow_sync_q <= 3'h0;
      slow_level_q <= 1'b0;
    end else begin
      pin_sync_q  <= {pin_sync_q[1:0], ext_pin_i};
      slow_sync_q <= {slow_sync_q[1:0], slow_sub_clk_i};
      if (pin_sync_q[1] == pin_sync_q[2]) begin
        pin_level_q <= pin_sync_q[2];
      end
      if (slow_sync_q[1] == slow_sync_q[2]) begin
        slow_level_q <= slow_sync_q[2];
      end
    end
  end

  // edge detection on the filtered pin level
  logic pin_rise;
  logic pin_fall;
  logic slow_rise;
  assign pin_rise  = (pin_sync_q[1] == pin_sync_q[2]) && pin_sync_q[2] && !pin_level_q;
  assign pin_fall  = (pin_sync_q[1] == pin_sync_q[2]) && !pin_sync_q[2] && pin_level_q;
  assign slow_rise = (slow_sync_q[1] == slow_sync_q[2]) && slow_sync_q[2] && !slow_level_q;

  always_comb begin
    event_d = '0;
    case (irq_tb_pkg::edge_mode_t'(ext_edge_select_q))
      irq_tb_pkg::EDGE_RISE: event_d[S_EXT] = pin_rise;
      irq_tb_pkg::EDGE_FALL: event_d[S_EXT] = pin_fall;
      irq_tb_pkg::EDGE_BOTH: event_d[S_EXT] = pin_rise | pin_fall;
      default:               event_d[S_EXT] = 1'b0;
    endcase
    event_d[S_SER] = serial_event_i;
    event_d[S_ADC] = conv_done_i;
    event_d[S_EEP] = eeprom_write_done_i;
    event_d[S_MP]  = match_p_i;
    event_d[S_MA]  = match_a_i;
    event_d[S_TB0] = tb0_ovf;
    event_d[S_TB1] = tb1_ovf;
  end

  // prescaler clock: system, system/4 or the slow clock
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div4_q <= 2'h0;
    end else begin
      div4_q <= div4_q + 2'h1;
    end
  end
  always_comb begin
    case (prescaler_src_sel_q)
      2'h0:    psc_tick = 1'b1;
      2'h1:    psc_tick = (div4_q == `DIV4_COUNT);
      default: psc_tick = slow_rise;
    endcase
  end

  tick_divider u_tick0 (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .tick_i       (psc_tick),
    .run_i        (tick0_run_q),
    .period_sel_i (tick0_period_sel_q),
    .overflow_o   (tb0_ovf)
  );
  tick_divider u_tick1 (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .tick_i       (psc_tick),
    .run_i        (tick1_run_q),
    .period_sel_i (tick1_period_sel_q),
    .overflow_o   (tb1_ovf)
  );

  // fixed priority pick, lowest index wins
  always_comb begin
    pending = flag_q & enable_q;
    winner  = 3'h0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (pending[i]) begin
        winner = 3'(i);
      end
    end
    // stack full holds acknowledge off; core drops it after popping
    any_pending = (|pending) && global_irq_enable_q && !stack_full_i;
  end

  // core handshake: the core offers a window at an instruction boundary
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q    <= irq_tb_pkg::ST_IDLE;
      irq_take_o <= 1'b0;
      push_pc_o  <= 12'h000;
      vector_o   <= 12'h000;
      svc_clear  <= '0;
    end else begin
      irq_take_o <= 1'b0;
      svc_clear  <= '0;
      case (state_q)
        irq_tb_pkg::ST_IDLE: begin
          if (irq_window_i && any_pending) begin
            irq_take_o <= 1'b1;
            push_pc_o  <= next_pc_i;
            vector_o   <= `VEC_BASE + `VEC_STEP * 12'(winner);
            svc_clear  <= NSRC'(1) << winner;
            state_q    <= irq_tb_pkg::ST_ENTER;
          end
        end
        irq_tb_pkg::ST_ENTER: state_q <= irq_tb_pkg::ST_ACK;
        irq_tb_pkg::ST_ACK:   state_q <= irq_tb_pkg::ST_IDLE;
        default:              state_q <= irq_tb_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pop_o <= 1'b0;
    end else begin
      pop_o <= return_from_irq_i;
    end
  end

  // wishbone decode; a write lands on the edge at which the master sees ack high
  assign bus_req = cyc_i && stb_i && !ack_o;
  assign bus_wr  = cyc_i && stb_i && ack_o && we_i && sel_i[0];

  always_comb begin
    wr_mask  = '0;
    wr_value = '0;
    if (bus_wr && adr_i == `OFS_CTRL0) begin
      wr_mask[S_SER]  = 1'b1;
      wr_mask[S_EXT]  = 1'b1;
      wr_value[S_SER] = dat_i[5];
      wr_value[S_EXT] = dat_i[4];
    end
    if (bus_wr && adr_i == `OFS_CTRL1) begin
      wr_mask[S_MA:S_ADC]  = 4'hF;
      wr_value[S_ADC] = dat_i[4];
      wr_value[S_EEP] = dat_i[5];
      wr_value[S_MP]  = dat_i[6];
      wr_value[S_MA]  = dat_i[7];
    end
    if (bus_wr && adr_i == `OFS_CTRL2) begin
      wr_mask[S_TB1:S_TB0]  = 2'h3;
      wr_value[S_TB0] = dat_i[4];
      wr_value[S_TB1] = dat_i[5];
    end
  end

  // flags: event beats software clear and service clear; set during block is kept
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_q <= '0;
    end else begin
      // uart status bits live in the serial module; only our flag clears
      flag_q <= ((flag_q & ~svc_clear & ~wr_mask) | (wr_value & wr_mask))
                | event_d;
    end
  end

  logic [NSRC-1:0] flag_prev_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_prev_q <= '0;
      wake_o      <= 1'b0;
    end else begin
      flag_prev_q <= flag_q;
      wake_o      <= |(flag_q & ~flag_prev_q);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      global_irq_enable_q <= 1'b0;
      enable_q            <= '0;
      ext_edge_select_q   <= 2'h0;
      prescaler_src_sel_q <= 2'h0;
      tick0_run_q         <= 1'b0;
      tick0_period_sel_q  <= 3'h0;
      tick1_run_q         <= 1'b0;
      tick1_period_sel_q  <= 3'h0;
    end else begin
      if (bus_wr) begin
        case (adr_i)
          `OFS_EDGE_SEL: ext_edge_select_q <= dat_i[1:0];
          `OFS_CTRL0: begin
            global_irq_enable_q <= dat_i[0];
            enable_q[S_EXT]     <= dat_i[1];
            enable_q[S_SER]     <= dat_i[2];
          end
          `OFS_CTRL1: begin
            enable_q[S_ADC] <= dat_i[0];
            enable_q[S_EEP] <= dat_i[1];
            enable_q[S_MP]  <= dat_i[2];
            enable_q[S_MA]  <= dat_i[3];
          end
          `OFS_CTRL2: begin
            enable_q[S_TB0] <= dat_i[0];
            enable_q[S_TB1] <= dat_i[1];
          end
          `OFS_PRESCALER: prescaler_src_sel_q <= dat_i[1:0];
          `OFS_TICK0: begin
            tick0_run_q        <= dat_i[`BIT_RUN];
            tick0_period_sel_q <= dat_i[2:0];
          end
          `OFS_TICK1: begin
            tick1_run_q        <= dat_i[`BIT_RUN];
            tick1_period_sel_q <= dat_i[2:0];
          end
          default: ;
        endcase
      end
      if (state_q == irq_tb_pkg::ST_IDLE && irq_window_i && any_pending) begin
        global_irq_enable_q <= 1'b0;
      end else if (return_from_irq_i) begin
        global_irq_enable_q <= 1'b1;
      end
    end
  end

  // reads answer in one cycle; unmapped offsets read zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= `RST_BYTE;
    end else begin
      ack_o <= bus_req;
      if (bus_req) begin
        case (adr_i)
          `OFS_EDGE_SEL:  dat_o <= {6'h00, ext_edge_select_q};
          `OFS_CTRL0:     dat_o <= {2'h0, flag_q[S_SER], flag_q[S_EXT], 1'b0,
                                    enable_q[S_SER], enable_q[S_EXT], global_irq_enable_q};
          `OFS_CTRL1:     dat_o <= {flag_q[S_MA:S_ADC], enable_q[S_MA:S_ADC]};
          `OFS_CTRL2:     dat_o <= {2'h0, flag_q[S_TB1:S_TB0], 2'h0, enable_q[S_TB1:S_TB0]};
          `OFS_PRESCALER: dat_o <= {6'h00, prescaler_src_sel_q};
          `OFS_TICK0:     dat_o <= {tick0_run_q, 4'h0, tick0_period_sel_q};
          `OFS_TICK1:     dat_o <= {tick1_run_q, 4'h0, tick1_period_sel_q};
          `OFS_CORE:      dat_o <= {6'h00, stack_full_i, 1'b0};
          default:        dat_o <= 8'h00;
        endcase
      end
    end
  end
endmodule : vectored_irq

// ===== sim/vectored_irq_assertions.sv
// port assertions for the interrupt controller
`timescale 1ns/10ps
module vectored_irq_assertions (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        ack_o,
  input wire logic        irq_window_i,
  input wire logic        stack_full_i,
  input wire logic        return_from_irq_i,
  input wire logic [11:0] next_pc_i,
  input wire logic        irq_take_o,
  input wire logic [11:0] push_pc_o,
  input wire logic [11:0] vector_o,
  input wire logic        pop_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("no ack one cycle after request");
  a_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");
  a_take_cause: assert property (
    irq_take_o |-> $past(irq_window_i) && !$past(stack_full_i)) else $error("take not allowed");
  a_take_spacing: assert property (irq_take_o |=> !irq_take_o [*2])
    else $error("takes too close");
  a_push_pc: assert property (irq_take_o |-> push_pc_o == $past(next_pc_i))
    else $error("wrong pc pushed");
  a_vector_range: assert property (
    irq_take_o |-> vector_o[1:0] == 2'h0 && vector_o >= 12'h004 && vector_o <= 12'h020)
    else $error("vector out of table");
  a_vector_hold: assert property (!irq_take_o |-> $stable(vector_o))
    else $error("vector moved without take");
  a_pop_after: assert property (return_from_irq_i |=> pop_o)
    else $error("no pop after return");
  a_pop_cause: assert property (pop_o |-> $past(return_from_irq_i))
    else $error("pop without return");
endmodule : vectored_irq_assertions

// ===== sim/core_model.sv
// core stand-in: program counter, return stack, return requests
`timescale 1ns/10ps
module core_model #(
  parameter int DEPTH = 1
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ret_req_i,
  input  wire logic        irq_take_i,
  input  wire logic [11:0] push_pc_i,
  input  wire logic [11:0] vector_i,
  input  wire logic        pop_i,
  output logic [11:0]      next_pc_o,
  output logic             return_from_irq_o,
  output logic             stack_full_o
);
  logic [11:0] pc_q;
  logic [11:0] stack_q [0:7];
  int          depth_q;
  assign next_pc_o    = pc_q + 12'h001;
  // a depth of one makes every taken irq fill the stack
  assign stack_full_o = depth_q >= DEPTH;
  always_ff @(posedge clk_i) begin
    return_from_irq_o <= ret_req_i && !rst_i;
    if (rst_i) begin
      pc_q    <= 12'h000;
      depth_q <= 0;
    end else if (irq_take_i) begin
      stack_q[depth_q] <= push_pc_i;
      depth_q          <= depth_q + 1;
      pc_q             <= vector_i;
    end else if (pop_i) begin
      depth_q <= depth_q - 1;
      pc_q    <= stack_q[depth_q-1];
    end else pc_q <= pc_q + 12'h001;
  end
endmodule : core_model

// ===== sim/testbench.sv
// self-checking bench for the interrupt controller
`timescale 1ns/10ps
`include "irq_tb_map.svh"
module testbench;
  logic        clk_i, rst_i, cyc_i, stb_i, we_i, pin, slow, ret_req, ack, take, pop, wake;
  logic        full, ret;
  logic [3:0]  adr;
  logic [7:0]  dat, rdat, q;
  logic [4:0]  ev;
  logic [11:0] npc, push_pc, vec;
  int          n_mismatch, checks, cyc_cnt, wakes;
  vectored_irq i_vectored_irq (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr), .dat_i(dat),
    .we_i(we_i), .sel_i(1'b1), .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(rdat), .ack_o(ack),
    .ext_pin_i(pin), .slow_sub_clk_i(slow), .conv_done_i(ev[0]), .eeprom_write_done_i(ev[1]),
    .match_p_i(ev[2]), .match_a_i(ev[3]), .serial_event_i(ev[4]), .next_pc_i(npc),
    .irq_window_i(1'b1), .return_from_irq_i(ret), .stack_full_i(full), .irq_take_o(take),
    .push_pc_o(push_pc), .vector_o(vec), .pop_o(pop), .wake_o(wake));
  core_model i_core_model (.clk_i(clk_i), .rst_i(rst_i), .ret_req_i(ret_req),
    .irq_take_i(take), .push_pc_i(push_pc), .vector_i(vec), .pop_i(pop), .next_pc_o(npc),
    .return_from_irq_o(ret), .stack_full_o(full));
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  // slow clock rises every 6 cycles so it cannot pass for the divide-by-four tick
  initial begin
    slow = 1'b0;
    forever begin
      repeat (3) @(posedge clk_i);
      slow <= ~slow;
    end
  end
  always @(posedge clk_i) begin
    wakes   <= wakes + int'(wake === 1'b1);
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 60000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish;
    if (n_mismatch == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic [3:0] a, input logic [7:0] d, input logic w);
    int n;
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr, dat} <= {2'b11, w, a, d};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    chk({11'h000, ack}, 12'h001);
    q = rdat;
    {cyc_i, stb_i} <= 2'b00;
  endtask : bus
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    bus(a, 8'h00, 1'b0);
    chk({4'h0, q}, {4'h0, e});
  endtask : rd
  task automatic fire(input logic [4:0] m);
    @(posedge clk_i) ev <= m;
    @(posedge clk_i) ev <= 5'h00;
  endtask : fire
  task automatic rtn;
    @(posedge clk_i) ret_req <= 1'b1;
    @(posedge clk_i) ret_req <= 1'b0;
  endtask : rtn
  task automatic expect_take(input logic [11:0] e);
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (take !== 1'b1 && n < 40);
    chk({11'h000, take}, 12'h001);
    chk(vec, e);
  endtask : expect_take
  task automatic no_take(input int n);
    repeat (n) begin
      @(posedge clk_i);
      chk({11'h000, take}, 12'h000);
    end
  endtask : no_take
  // flag must stay clear short of the period and be set just after it
  task automatic tick(input logic [3:0] a, input logic [7:0] v, input logic [7:0] f,
                      input int per);
    bus(`OFS_CTRL2, 8'h00, 1'b1);
    bus(a, v, 1'b1);
    repeat (per - 30) @(posedge clk_i);
    rd(`OFS_CTRL2, 8'h00);
    repeat (50) @(posedge clk_i);
    rd(`OFS_CTRL2, f);
    bus(a, 8'h00, 1'b1);
  endtask : tick
  initial begin
    {rst_i, cyc_i, stb_i, we_i, pin, ret_req, adr, dat, ev} = {6'b100000, 17'h00000};
    n_mismatch = 0;
    checks = 0;
    cyc_cnt = 0;
    wakes = 0;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int a = 0; a < 8; a++) rd(4'(a), 8'h00);
    bus(4'h8, 8'hFF, 1'b1);
    rd(4'h8, 8'h00);
    bus(`OFS_EDGE_SEL, 8'hFF, 1'b1);
    rd(`OFS_EDGE_SEL, 8'h03);
    bus(`OFS_PRESCALER, 8'hFF, 1'b1);
    rd(`OFS_PRESCALER, 8'h03);
    bus(`OFS_TICK0, 8'hFF, 1'b1);
    rd(`OFS_TICK0, 8'h87);
    bus(`OFS_TICK0, 8'h00, 1'b1);
    bus(`OFS_PRESCALER, 8'h00, 1'b1);
    fire(5'h1F);
    rd(`OFS_CTRL1, 8'hF0);
    rd(`OFS_CTRL0, 8'h20);
    chk(12'(wakes), 12'h001);
    fire(5'h01);
    rd(`OFS_CTRL1, 8'hF0);
    chk(12'(wakes), 12'h001);
    // writing the enables also writes zero flags, so the events come again while blocked
    bus(`OFS_CTRL1, 8'h0F, 1'b1);
    bus(`OFS_CTRL0, 8'h24, 1'b1);
    fire(5'h1F);
    no_take(20);
    rd(`OFS_CTRL1, 8'hFF);
    chk(12'(wakes), 12'h002);
    bus(`OFS_CTRL0, 8'h25, 1'b1);
    expect_take(12'h008);
    rd(`OFS_CTRL0, 8'h04);
    for (int i = 2; i < 6; i++) begin
      rtn();
      expect_take(12'h004 + 12'(4 * i));
    end
    rd(`OFS_CTRL1, 8'h0F);
    fire(5'h04);
    rd(`OFS_CORE, 8'h02);
    bus(`OFS_CTRL0, 8'h05, 1'b1);
    no_take(10);
    rtn();
    expect_take(12'h014);
    rtn();
    bus(`OFS_CTRL1, 8'h00, 1'b1);
    for (int m = 0; m < 4; m++) begin
      bus(`OFS_EDGE_SEL, 8'(m), 1'b1);
      bus(`OFS_CTRL0, 8'h00, 1'b1);
      pin <= 1'b1;
      repeat (8) @(posedge clk_i);
      rd(`OFS_CTRL0, m[0] ? 8'h10 : 8'h00);
      bus(`OFS_CTRL0, 8'h00, 1'b1);
      pin <= 1'b0;
      repeat (8) @(posedge clk_i);
      rd(`OFS_CTRL0, m[1] ? 8'h10 : 8'h00);
    end
    bus(`OFS_EDGE_SEL, 8'h01, 1'b1);
    bus(`OFS_CTRL0, 8'h03, 1'b1);
    pin <= 1'b1;
    expect_take(12'h004);
    rtn();
    bus(`OFS_CTRL0, 8'h00, 1'b1);
    // shortest period with the run bit clear: a divider that ignored it would flag by now
    bus(`OFS_TICK0, 8'h00, 1'b1);
    repeat (300) @(posedge clk_i);
    rd(`OFS_CTRL2, 8'h00);
    tick(`OFS_TICK0, 8'h80, 8'h10, 256);
    tick(`OFS_TICK1, 8'h81, 8'h20, 512);
    tick(`OFS_TICK1, 8'h87, 8'h20, 32768);
    bus(`OFS_PRESCALER, 8'h01, 1'b1);
    tick(`OFS_TICK0, 8'h80, 8'h10, 1024);
    bus(`OFS_PRESCALER, 8'h02, 1'b1);
    tick(`OFS_TICK1, 8'h80, 8'h20, 1536);
    tally_and_finish();
  end
endmodule : testbench
bind vectored_irq vectored_irq_assertions i_vectored_irq_assertions (.clk_i(clk_i),
  .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .irq_window_i(irq_window_i),
  .stack_full_i(stack_full_i), .return_from_irq_i(return_from_irq_i), .next_pc_i(next_pc_i),
  .irq_take_o(irq_take_o), .push_pc_o(push_pc_o), .vector_o(vector_o), .pop_o(pop_o));
